//--- common/diag_pkg.sv
/*
   Shared constants of the motor driver diagnostic and protection monitor:
   register offsets, field positions and widths.
   Assumes a register port with a 4-bit byte address and 32-bit data.
*/
package diag_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int COIL_N = 2;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CONFIG = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'hc;

   // config field layout
   localparam int CFG_OTSEL_BIT = 0;
   localparam int CFG_SLOPE_LSB = 1;
   localparam int SLOPE_W = 2;
   localparam int CFG_CS_LSB = 3;
   localparam int CS_W = 5;
   localparam int SLOPE_COMP_BIT = 1;

   // status field layout
   localparam int ST_OL_LSB = 0;
   localparam int ST_WARN_BIT = 2;
   localparam int ST_SHDN_BIT = 3;
   localparam int ST_DRV_BIT = 4;
   localparam int ST_CS_LSB = 8;

   // interrupt status and mask layout
   localparam int IRQ_W = 4;
   localparam int IRQ_OL_LSB = 0;
   localparam int IRQ_WARN_BIT = 2;
   localparam int IRQ_SHDN_BIT = 3;

   // gate current output and low-current threshold (one sixteenth)
   localparam int GATE_CUR_W = 3;
   localparam int CUR_LOW_SHIFT = 4;
   localparam logic [GATE_CUR_W-1:0] GATE_CUR_STEP = 3'h1;
endpackage

//--- core/diag_monitor.sv
/*
   Diagnostic and protection monitor of a two-phase stepper driver: per-coil
   open-load flags, two-level overtemperature flags with release hysteresis,
   temperature-compensated high-side gate current, undervoltage reset.
   Assumes every input is synchronous to SYS_CLK_IN, temperature and supply
   comparators arrive as ready-made levels, and coil current is a magnitude.
*/
// Contract
// - set a coil's open-load flag if no chopper event in last constant-polarity period
// - keep open-load flags unchanged while coil current is below 1/16 of maximum
// - open-load flags only indicate; driver and bridges never react to them
// - warning flag set whenever the sensor reports 100 degC reached
// - at shutdown threshold, default 150 degC, disable driver and set shutdown flag
// - reduced-threshold bit picks shutdown level: 0 gives 150 degC, 1 gives 136 degC
// - enhanced variant keeps driver off until temperature falls below 120 degC
// - compensated slope modes raise high-side gate current one step at warning
// - undervoltage flagged when logic supply or main supply is too low
// - undervoltage detector is also the power-up reset of the control logic
// - during undervoltage hold logic in reset and disable the driver
// - during undervoltage switch off every power gate output
// - during undervoltage clear every configuration register to zero
// - during undervoltage reads return all zeros and nothing passes through
// - after undervoltage current scale is zero, so its status reads zero
`timescale 1ns/1ps

module diag_monitor #(
   parameter int CUR_W = 8,
   parameter bit ENHANCED = 1'b1
) (
   input wire logic SYS_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic [diag_pkg::ADDR_W-1:0] ADDR_IN,
   input wire logic [diag_pkg::DATA_W-1:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [diag_pkg::COIL_N-1:0] CHOP_EVT_IN,
   input wire logic [diag_pkg::COIL_N-1:0] COIL_POL_IN,
   input wire logic [diag_pkg::COIL_N*CUR_W-1:0] COIL_CUR_IN,
   input wire logic [CUR_W-1:0] CUR_MAX_IN,
   input wire logic TEMP_WARN_IN,
   input wire logic TEMP_SHDN_HI_IN,
   input wire logic TEMP_SHDN_LO_IN,
   input wire logic TEMP_ABOVE_REL_IN,
   input wire logic VLOGIC_LOW_IN,
   input wire logic VSUPPLY_LOW_IN,
   output logic [diag_pkg::DATA_W-1:0] RDATA_OUT,
   output logic DRIVER_EN_OUT,
   output logic GATE_ON_ALLOWED_OUT,
   output logic [diag_pkg::GATE_CUR_W-1:0] HS_GATE_CUR_OUT,
   output logic LOGIC_RESET_OUT,
   output logic IRQ_OUT
);
   localparam int CW = CUR_W + diag_pkg::CUR_LOW_SHIFT;

   typedef struct packed {
      logic otsel;
      logic [diag_pkg::SLOPE_W-1:0] slope;
      logic [diag_pkg::CS_W-1:0] cs;
      logic [diag_pkg::COIL_N-1:0] ol;
      logic [diag_pkg::COIL_N-1:0] pol;
      logic [diag_pkg::COIL_N-1:0] evt_seen;
      logic warn;
      logic shdn;
      logic drv_en;
      logic gate_on;
      logic [diag_pkg::GATE_CUR_W-1:0] hs_cur;
      logic logic_rst;
      logic [diag_pkg::IRQ_W-1:0] irq_st;
      logic [diag_pkg::IRQ_W-1:0] irq_mask;
      logic [diag_pkg::DATA_W-1:0] rdata;
      logic irq;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   logic uv;
   logic [diag_pkg::COIL_N-1:0] cur_low;
   logic shdn_hit;

   // true when coil current sits below one sixteenth of the maximum setting
   function automatic logic below_sixteenth(input logic [CUR_W-1:0] cur,
                                            input logic [CUR_W-1:0] max);
      logic [CW-1:0] cur_x16;
      logic [CW-1:0] max_w;
      cur_x16 = {cur, {diag_pkg::CUR_LOW_SHIFT{1'b0}}};
      max_w = {{diag_pkg::CUR_LOW_SHIFT{1'b0}}, max};
      return cur_x16 < max_w;
   endfunction

   function automatic logic [diag_pkg::DATA_W-1:0] status_word(input state_t s);
      logic [diag_pkg::DATA_W-1:0] w;
      w = '0;
      w[diag_pkg::ST_OL_LSB +: diag_pkg::COIL_N] = s.ol;
      w[diag_pkg::ST_WARN_BIT] = s.warn;
      w[diag_pkg::ST_SHDN_BIT] = s.shdn;
      w[diag_pkg::ST_DRV_BIT] = s.drv_en;
      w[diag_pkg::ST_CS_LSB +: diag_pkg::CS_W] = s.cs;
      return w;
   endfunction

   assign uv = VLOGIC_LOW_IN | VSUPPLY_LOW_IN;

   generate
      for (genvar c = 0; c < diag_pkg::COIL_N; c++) begin : g_low
         assign cur_low[c] = below_sixteenth(COIL_CUR_IN[c*CUR_W +: CUR_W], CUR_MAX_IN);
      end
   endgenerate

   // reduced threshold picks the lower comparator
   assign shdn_hit = s_r.otsel ? TEMP_SHDN_LO_IN : TEMP_SHDN_HI_IN;

   always_comb begin
      logic [diag_pkg::IRQ_W-1:0] evts;
      logic [diag_pkg::DATA_W-1:0] cfg_word;
      s_nxt = s_r;
      evts = '0;
      cfg_word = '0;
      cfg_word[diag_pkg::CFG_OTSEL_BIT] = s_r.otsel;
      cfg_word[diag_pkg::CFG_SLOPE_LSB +: diag_pkg::SLOPE_W] = s_r.slope;
      cfg_word[diag_pkg::CFG_CS_LSB +: diag_pkg::CS_W] = s_r.cs;

      // open-load: judged at each polarity change, the end of a period
      for (int c = 0; c < diag_pkg::COIL_N; c++) begin
         s_nxt.pol[c] = COIL_POL_IN[c];
         if (COIL_POL_IN[c] != s_r.pol[c]) begin
            if (!cur_low[c]) begin
               s_nxt.ol[c] = !(s_r.evt_seen[c] | CHOP_EVT_IN[c]);
            end
            s_nxt.evt_seen[c] = 1'b0;
         end else begin
            s_nxt.evt_seen[c] = s_r.evt_seen[c] | CHOP_EVT_IN[c];
         end
         evts[diag_pkg::IRQ_OL_LSB + c] = s_nxt.ol[c] & ~s_r.ol[c];
      end

      s_nxt.warn = TEMP_WARN_IN;
      evts[diag_pkg::IRQ_WARN_BIT] = TEMP_WARN_IN & ~s_r.warn;

      // latched shutdown; the enhanced part waits for the release level
      if (shdn_hit) begin
         s_nxt.shdn = 1'b1;
      end else if (s_r.shdn) begin
         if (ENHANCED) begin
            s_nxt.shdn = TEMP_ABOVE_REL_IN;
         end else begin
            s_nxt.shdn = 1'b0;
         end
      end
      evts[diag_pkg::IRQ_SHDN_BIT] = s_nxt.shdn & ~s_r.shdn;

      // open-load flags are deliberately kept out of this term
      s_nxt.drv_en = !s_nxt.shdn;
      s_nxt.gate_on = !s_nxt.shdn;

      // one extra step only in the compensated modes
      if (s_r.slope[diag_pkg::SLOPE_COMP_BIT] && s_r.warn) begin
         s_nxt.hs_cur = {1'b0, s_r.slope} + diag_pkg::GATE_CUR_STEP;
      end else begin
         s_nxt.hs_cur = {1'b0, s_r.slope};
      end

      s_nxt.logic_rst = 1'b0;
      s_nxt.rdata = '0;
      if (RD_IN) begin
         case (ADDR_IN)
            diag_pkg::OFF_CONFIG: s_nxt.rdata = cfg_word;
            diag_pkg::OFF_STATUS: s_nxt.rdata = status_word(s_r);
            diag_pkg::OFF_IRQ_STATUS: begin
               s_nxt.rdata = {{(diag_pkg::DATA_W-diag_pkg::IRQ_W){1'b0}}, s_r.irq_st};
            end
            diag_pkg::OFF_IRQ_MASK: begin
               s_nxt.rdata = {{(diag_pkg::DATA_W-diag_pkg::IRQ_W){1'b0}}, s_r.irq_mask};
            end
            default: s_nxt.rdata = '0;
         endcase
      end
      if (WR_IN) begin
         case (ADDR_IN)
            diag_pkg::OFF_CONFIG: begin
               s_nxt.otsel = WDATA_IN[diag_pkg::CFG_OTSEL_BIT];
               s_nxt.slope = WDATA_IN[diag_pkg::CFG_SLOPE_LSB +: diag_pkg::SLOPE_W];
               s_nxt.cs = WDATA_IN[diag_pkg::CFG_CS_LSB +: diag_pkg::CS_W];
            end
            diag_pkg::OFF_IRQ_MASK: s_nxt.irq_mask = WDATA_IN[diag_pkg::IRQ_W-1:0];
            default: s_nxt.irq_mask = s_r.irq_mask;
         endcase
      end

      // read clears, but an event in the same cycle still lands
      if (RD_IN && ADDR_IN == diag_pkg::OFF_IRQ_STATUS) begin
         s_nxt.irq_st = evts;
      end else begin
         s_nxt.irq_st = s_r.irq_st | evts;
      end
      s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);

      // undervoltage overrides everything: whole state back to zero except logic_rst, which is set
      if (uv) begin
         s_nxt = '0;
         s_nxt.logic_rst = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign RDATA_OUT = s_r.rdata;
   assign DRIVER_EN_OUT = s_r.drv_en;
   assign GATE_ON_ALLOWED_OUT = s_r.gate_on;
   assign HS_GATE_CUR_OUT = s_r.hs_cur;
   assign LOGIC_RESET_OUT = s_r.logic_rst;
   assign IRQ_OUT = s_r.irq;

   property p_ol_set;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && COIL_POL_IN[0] != s_r.pol[0] && !cur_low[0] && !s_r.evt_seen[0]
       && !CHOP_EVT_IN[0]) |=> s_r.ol[0];
   endproperty
   a_ol_set: assert property (p_ol_set) else $error("open-load A not set");

   property p_ol_clear;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && COIL_POL_IN[1] != s_r.pol[1] && !cur_low[1] && CHOP_EVT_IN[1])
      |=> !s_r.ol[1];
   endproperty
   a_ol_clear: assert property (p_ol_clear) else $error("open-load B not cleared");

   property p_ol_hold_low;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && cur_low[0]) |=> (s_r.ol[0] == $past(s_r.ol[0]));
   endproperty
   a_ol_hold_low: assert property (p_ol_hold_low) else $error("open-load changed at low current");

   property p_warn;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      !uv |=> (s_r.warn == $past(TEMP_WARN_IN));
   endproperty
   a_warn: assert property (p_warn) else $error("warning flag missing");

   property p_shdn;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && !s_r.otsel && TEMP_SHDN_HI_IN) |=> (s_r.shdn && !DRIVER_EN_OUT);
   endproperty
   a_shdn: assert property (p_shdn) else $error("shutdown not taken at high level");

   property p_shdn_lo;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && s_r.otsel && TEMP_SHDN_LO_IN) |=> (s_r.shdn && !GATE_ON_ALLOWED_OUT);
   endproperty
   a_shdn_lo: assert property (p_shdn_lo) else $error("reduced threshold ignored");

   property p_release;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (ENHANCED && !uv && s_r.shdn && TEMP_ABOVE_REL_IN) |=> (s_r.shdn && !DRIVER_EN_OUT);
   endproperty
   a_release: assert property (p_release) else $error("driver released above 120 degC");

   property p_gate_cur;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && s_r.warn && s_r.slope[diag_pkg::SLOPE_COMP_BIT])
      |=> (HS_GATE_CUR_OUT == {1'b0, $past(s_r.slope)} + diag_pkg::GATE_CUR_STEP);
   endproperty
   a_gate_cur: assert property (p_gate_cur) else $error("gate current not raised one step");

   property p_uv_off;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (VLOGIC_LOW_IN || VSUPPLY_LOW_IN)
      |=> (LOGIC_RESET_OUT && !DRIVER_EN_OUT && !GATE_ON_ALLOWED_OUT);
   endproperty
   a_uv_off: assert property (p_uv_off) else $error("undervoltage did not switch off");

   property p_uv_clear;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      uv |=> (s_r.cs == '0 && !s_r.otsel && s_r.slope == '0 && s_r.irq_mask == '0);
   endproperty
   a_uv_clear: assert property (p_uv_clear) else $error("config not cleared");

   property p_uv_read;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (uv && RD_IN) |=> (RDATA_OUT == '0);
   endproperty
   a_uv_read: assert property (p_uv_read) else $error("read not zero in undervoltage");

   property p_uv_cs;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (uv ##1 (!uv && !WR_IN) ##1 (!uv && RD_IN && ADDR_IN == diag_pkg::OFF_STATUS))
      |=> (RDATA_OUT[diag_pkg::ST_CS_LSB +: diag_pkg::CS_W] == '0);
   endproperty
   a_uv_cs: assert property (p_uv_cs) else $error("current scale not zero after uv");

   property p_ol_set_b;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && COIL_POL_IN[1] != s_r.pol[1] && !cur_low[1] && !s_r.evt_seen[1]
       && !CHOP_EVT_IN[1]) |=> s_r.ol[1];
   endproperty
   a_ol_set_b: assert property (p_ol_set_b) else $error("open-load B not set");

   property p_ol_hold_low_b;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && cur_low[1]) |=> (s_r.ol[1] == $past(s_r.ol[1]));
   endproperty
   a_ol_hold_low_b: assert property (p_ol_hold_low_b) else $error("open-load B changed");

   property p_no_ol_action;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      !uv |=> (DRIVER_EN_OUT == !s_r.shdn && GATE_ON_ALLOWED_OUT == !s_r.shdn);
   endproperty
   a_no_ol_action: assert property (p_no_ol_action) else $error("driver follows open-load");

   property p_warn_irq;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && TEMP_WARN_IN && !s_r.warn) |=> s_r.irq_st[diag_pkg::IRQ_WARN_BIT];
   endproperty
   a_warn_irq: assert property (p_warn_irq) else $error("warning event lost");

   property p_shdn_irq;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && !s_r.shdn && shdn_hit) |=> s_r.irq_st[diag_pkg::IRQ_SHDN_BIT];
   endproperty
   a_shdn_irq: assert property (p_shdn_irq) else $error("shutdown event lost");

   property p_otsel_hi_ignored;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && s_r.otsel && !s_r.shdn && !TEMP_SHDN_LO_IN) |=> !s_r.shdn;
   endproperty
   a_otsel_hi_ignored: assert property (p_otsel_hi_ignored) else $error("wrong level used");

   property p_release_done;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && s_r.shdn && !shdn_hit && !TEMP_ABOVE_REL_IN)
      |=> (!s_r.shdn && DRIVER_EN_OUT);
   endproperty
   a_release_done: assert property (p_release_done) else $error("driver not released");

   property p_hs_plain;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && !(s_r.warn && s_r.slope[diag_pkg::SLOPE_COMP_BIT]))
      |=> (HS_GATE_CUR_OUT == {1'b0, $past(s_r.slope)});
   endproperty
   a_hs_plain: assert property (p_hs_plain) else $error("gate current raised needlessly");

   property p_uv_logic;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (VLOGIC_LOW_IN && !VSUPPLY_LOW_IN) |=> LOGIC_RESET_OUT;
   endproperty
   a_uv_logic: assert property (p_uv_logic) else $error("logic supply low missed");

   property p_uv_supply;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (VSUPPLY_LOW_IN && !VLOGIC_LOW_IN) |=> LOGIC_RESET_OUT;
   endproperty
   a_uv_supply: assert property (p_uv_supply) else $error("main supply low missed");

   property p_uv_status_zero;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      uv |=> (s_r.ol == '0 && !s_r.warn && !s_r.shdn && s_r.irq_st == '0
              && !IRQ_OUT);
   endproperty
   a_uv_status_zero: assert property (p_uv_status_zero) else $error("uv left flags set");

   property p_uv_gates;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      uv |=> (!GATE_ON_ALLOWED_OUT && HS_GATE_CUR_OUT == '0);
   endproperty
   a_uv_gates: assert property (p_uv_gates) else $error("gate drive on in uv");

   property p_status_read;
      @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (!uv && RD_IN && ADDR_IN == diag_pkg::OFF_STATUS)
      |=> (RDATA_OUT[diag_pkg::ST_OL_LSB +: diag_pkg::COIL_N] == $past(s_r.ol)
           && RDATA_OUT[diag_pkg::ST_WARN_BIT] == $past(s_r.warn)
           && RDATA_OUT[diag_pkg::ST_SHDN_BIT] == $past(s_r.shdn));
   endproperty
   a_status_read: assert property (p_status_read) else $error("flag not readable");
endmodule

//--- bench/host_model.sv
/*
   host side of the register port: single-cycle writes and reads.
   assumes the testbench calls its tasks and compares the read data itself.
*/
`timescale 1ns/1ps
module host_model (
   input wire logic clk_in,
   output logic [diag_pkg::ADDR_W-1:0] addr_out,
   output logic [diag_pkg::DATA_W-1:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial begin
      addr_out = '0;
      wdata_out = '0;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end

   // a zero current scale in a status word follows an undervoltage reset, but also a reset or a zero config write
   function automatic logic uv_seen(input logic [31:0] st);
      return st[12:8] == 5'h00;
   endfunction

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      wdata_out <= ~d;
   endtask

   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
   endtask
endmodule

//--- bench/motor_driver_diagnostics_monitor_tb.sv
/*
   self-checking bench of the diagnostic monitor: reads queue their expected word,
   a monitor compares the word in the cycle after the read strobe.
   assumes diag_pkg and host_model are compiled first.
*/
`timescale 1ns/1ps
module motor_driver_diagnostics_monitor_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] chop = '0, pol = '0;
   logic [15:0] cur = '0;
   logic [7:0] cur_max = 8'hf0;
   logic warn = 0, shi = 0, slo = 0, rel = 0, vl = 0, vs = 0, rd_q = 0;
   wire logic [3:0] addr;
   wire logic [31:0] wdata, rdata;
   wire logic bus_wr, bus_rd, drv, gate, lrst, irq;
   wire logic [2:0] hsc;
   logic [31:0] exp_q[$];
   logic [31:0] rnd, cfg;
   int errors = 0, check_count = 0, cyc = 0;
   integer seed = 32'h3779b0b3;

   always #5 clk = ~clk;

   host_model i_host_model (.clk_in(clk), .addr_out(addr), .wdata_out(wdata),
      .wr_out(bus_wr), .rd_out(bus_rd));

   diag_monitor i_diag_monitor (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
      .WDATA_IN(wdata), .WR_IN(bus_wr), .RD_IN(bus_rd), .CHOP_EVT_IN(chop),
      .COIL_POL_IN(pol), .COIL_CUR_IN(cur), .CUR_MAX_IN(cur_max), .TEMP_WARN_IN(warn),
      .TEMP_SHDN_HI_IN(shi), .TEMP_SHDN_LO_IN(slo), .TEMP_ABOVE_REL_IN(rel),
      .VLOGIC_LOW_IN(vl), .VSUPPLY_LOW_IN(vs), .RDATA_OUT(rdata), .DRIVER_EN_OUT(drv),
      .GATE_ON_ALLOWED_OUT(gate), .HS_GATE_CUR_OUT(hsc), .LOGIC_RESET_OUT(lrst),
      .IRQ_OUT(irq));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("errors %0d, checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // check one ns after the edge so the design's own updates have landed
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      i_host_model.rd_reg(a);
   endtask

   function automatic logic [31:0] st(input logic [1:0] ol, input logic w, s, d,
      input logic [4:0] cs);
      return {19'h0, cs, 3'h0, d, s, w, ol};
   endfunction

   always @(posedge clk) begin
      rd_q <= bus_rd;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         finish_test();
      end
   end

   always @(negedge clk) begin
      if (rd_q) begin
         check(rdata, exp_q.pop_front());
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      step(1);
      check({29'h0, drv, gate, lrst}, 32'h6);
      rd(diag_pkg::OFF_STATUS, st(2'h0, 0, 0, 1, 5'h00));
      rd(4'h1, 32'h0);
      i_host_model.wr_reg(diag_pkg::OFF_IRQ_MASK, 32'hf);
      rnd = $random(seed);
      cfg = {rnd[31:3], 3'b100}; // compensated slope, 150 degree level
      i_host_model.wr_reg(diag_pkg::OFF_CONFIG, cfg);
      i_host_model.wr_reg(diag_pkg::OFF_STATUS, 32'hffffffff);
      rd(diag_pkg::OFF_CONFIG, {24'h0, cfg[7:0]});
      rd(diag_pkg::OFF_STATUS, st(2'h0, 0, 0, 1, cfg[7:3]));
      // 0x0f is the smallest current not below 1/16 of 0xf0
      cur <= 16'h0f0f;
      pol <= 2'b11;
      step(2);
      check({30'h0, drv, irq}, 32'h3);
      rd(diag_pkg::OFF_STATUS, st(2'h3, 0, 0, 1, cfg[7:3]));
      chop <= 2'b01;
      step(1);
      // coil B's event falls in the polarity-change cycle itself
      chop <= 2'b10;
      pol <= 2'b00;
      step(1);
      chop <= 2'b00;
      step(1);
      rd(diag_pkg::OFF_STATUS, st(2'h0, 0, 0, 1, cfg[7:3]));
      // a maximum one above sixteen times the current makes it count as low
      cur_max <= 8'hf1;
      pol <= 2'b11;
      step(2);
      rd(diag_pkg::OFF_STATUS, st(2'h0, 0, 0, 1, cfg[7:3]));
      cur_max <= 8'hf0;
      pol <= 2'b00;
      step(2);
      rd(diag_pkg::OFF_STATUS, st(2'h3, 0, 0, 1, cfg[7:3]));
      rd(diag_pkg::OFF_IRQ_STATUS, 32'h3);
      step(2);
      check({31'h0, irq}, 32'h0);
      i_host_model.wr_reg(diag_pkg::OFF_IRQ_MASK, 32'h4);
      shi <= 1'b1;
      rel <= 1'b1;
      step(2);
      check({29'h0, drv, gate, irq}, 32'h0);
      rd(diag_pkg::OFF_STATUS, st(2'h3, 0, 1, 0, cfg[7:3]));
      shi <= 1'b0;
      step(2);
      check({31'h0, drv}, 32'h0);
      rel <= 1'b0;
      step(2);
      check({31'h0, drv}, 32'h1);
      warn <= 1'b1;
      slo <= 1'b1;
      step(2);
      check({27'h0, drv, hsc, irq}, {27'h0, 1'b1, 3'h3, 1'b1});
      i_host_model.wr_reg(diag_pkg::OFF_CONFIG, cfg | 32'h1);
      rel <= 1'b1;
      step(2);
      check({31'h0, drv}, 32'h0);
      rd(diag_pkg::OFF_STATUS, st(2'h3, 1, 1, 0, cfg[7:3]));
      slo <= 1'b0;
      rel <= 1'b0;
      warn <= 1'b0;
      step(2);
      check({28'h0, drv, hsc}, {28'h0, 1'b1, 3'h2});
      rd(diag_pkg::OFF_IRQ_STATUS, 32'hc);
      // both supply monitors in turn; writes during the reset must be dropped
      for (int i = 0; i < 2; i++) begin
         vl <= (i == 0);
         vs <= (i == 1);
         step(2);
         check({28'h0, lrst, drv, gate, irq}, 32'h8);
         i_host_model.wr_reg(diag_pkg::OFF_CONFIG, 32'hff);
         rd(diag_pkg::OFF_STATUS, 32'h0);
         vl <= 1'b0;
         vs <= 1'b0;
         rd(diag_pkg::OFF_STATUS, st(2'h0, 0, 0, 1, 5'h00));
         rd(diag_pkg::OFF_CONFIG, 32'h0);
      end
      step(3);
      finish_test();
   end
endmodule
